// ===== core/emul_port_pkg.sv
// Package for the bond-out emulation port: types and timing constants.
// Assumes a single 40 MHz clock domain; one clock tick is one phase.
package emul_port_pkg;
    localparam int unsigned SLOTS_PER_CYCLE = 10;
    localparam int unsigned PHASES_PER_SLOT = 3;
    localparam logic [3:0]  SLOT_FIRST      = 4'h1;
    localparam logic [3:0]  SLOT_LAST       = 4'ha;
    localparam logic [3:0]  SLOT_ADDR_CHG   = 4'h8;
    localparam logic [1:0]  PHASE_ADDR_CHG  = 2'h2;
    localparam logic [1:0]  PHASE_FIRST     = 2'h0;
    localparam logic [1:0]  PHASE_LAST      = 2'h2;
    localparam logic [3:0]  SLOT_STROBE_A   = 4'h9;
    localparam logic [3:0]  SLOT_STROBE_B   = 4'ha;
    localparam logic [3:0]  SLOT_FETCH_MARK = 4'ha;
    localparam logic [3:0]  SLOT_ACK_SET    = 4'h8;
    localparam logic [3:0]  SLOT_ACK_CLR    = 4'h7;
    localparam logic [3:0]  SLOT_SAMPLE     = 4'h7;
    localparam int unsigned ADDR_W          = 13;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned CODE_BYTES      = 8192;
    localparam logic [12:0] RESET_PC        = 13'h0000;
    localparam logic [12:0] VECTOR_EXT      = 13'h0003;
    localparam logic [12:0] VECTOR_SER      = 13'h0005;
    localparam logic [12:0] VECTOR_TMR      = 13'h0007;
    localparam logic [7:0]  OPC_START_COUNTER_INSTR    = 8'h45;
    localparam logic [7:0]  OPC_TWO_CYC_LO  = 8'h80;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_VEC1,
        ST_VEC2
    } core_state_e;

    typedef struct packed {
        logic prog_store_en_n;
        logic fetch_cycle_mark_n;
        logic irq_ack_n;
    } strobes_s;

    typedef struct packed {
        logic ext_irq_test0;
        logic test_one_input;
        logic ext_serial_irq_n;
        logic halt_n;
        logic small_pin_emul_sel_n;
    } pins_s;
endpackage : emul_port_pkg

// ===== core/pin_sync.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes pins are asynchronous to CLOCK_IN.
`timescale 1ns/1ps
module pin_sync
    import emul_port_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  rst_in,
    input  wire logic  ce_in,
    input  wire pins_s pins_in,
    output pins_s      pins_out
);
    pins_s meta_q;
    pins_s sync_q;
    localparam pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_q <= PINS_IDLE;
            sync_q <= PINS_IDLE;
        end
        else if (ce_in)
        begin
            meta_q <= pins_in;
            sync_q <= meta_q;
        end
    end

    assign pins_out = sync_q;
endmodule : pin_sync

// ===== core/bondout_emulation_port.sv
// Bond-out emulation port: slot timer, fetch sequencer and emulation pins.
// Assumes external code memory answers within one machine cycle.
`timescale 1ns/1ps
// Functional notes
// - Machine cycle is ten time slots, one to ten; strobes follow slots.
// - Code comes only from external memory over a 13-bit address.
// - Address outputs change only as slot nine begins, after phase three of slot eight.
// - Opcode bytes arrive active high on eight data inputs, bit0 lowest.
// - Store enable low in slots nine, ten and next cycle's slot one.
// - Fetch marker low from slot ten before a fetch to its slot ten.
// - Buffered clock output; phase clock rises with its rising edge.
// - Halt low: finish current instruction, then stop in halted state.
// - While halted the next program counter is on the address outputs.
// - While halted program counter and timer counter stay frozen.
// - On halt the serial unit finishes its action then goes idle.
// - Interrupts are sampled only while running, never while halted.
// - Acknowledge low from slot eight to slot seven of second vector cycle.
// - During acknowledge, return address shown; marker as a user call.
// - Falling edge on interrupt/test input requests; also jump-testable.
// - Processor held initialised while reset is high.
// - Active-low external serial interrupt accepted from the emulator in twenty-pin mode.
// - Twenty-pin select low makes the device act as that derivative.
// - Serial mode uses port 2 line 3 as data, dedicated clock pin.
// - Test-one jump-testable; event counter input after start-counter.
module bondout_emulation_port
    import emul_port_pkg::*;
(
    input  wire logic  CLOCK_IN,
    input  wire logic  RST_IN,
    input  wire logic  CE_IN,
    input  wire data_t FETCH_DATA_IN,
    input  wire logic  HALT_N_IN,
    input  wire logic  EXT_IRQ_TEST0_IN,
    input  wire logic  TEST_ONE_INPUT_IN,
    input  wire logic  EXT_SERIAL_IRQ_N_IN,
    input  wire logic  SMALL_PIN_EMUL_SEL_N_IN,
    input  wire logic  TIMER_IRQ_IN,
    input  wire logic  SERIAL_IRQ_IN,
    input  wire logic  SERIAL_BUSY_IN,
    input  wire logic  SERIAL_MODE_IN,
    output addr_t      FETCH_ADDR_OUT,
    output logic       PROG_STORE_EN_N_OUT,
    output logic       FETCH_CYCLE_MARK_N_OUT,
    output logic       IRQ_ACK_N_OUT,
    output logic       CLK_BUF_OUT,
    output logic       PHASE_CLK_OUT,
    output logic       HALTED_OUT,
    output logic       SERIAL_IDLE_REQ_OUT,
    output logic       TIMER_RUN_OUT,
    output logic       EVENT_CNT_EN_OUT,
    output logic       TEST0_LEVEL_OUT,
    output logic       TEST1_LEVEL_OUT,
    output logic       PIN20_MODE_OUT,
    output logic       SDA_ON_PORT2_LINE3_OUT,
    output data_t      OPCODE_OUT,
    output logic       OPCODE_VALID_OUT
);
    pins_s       pins_raw;
    pins_s       pins_s_w;
    logic [3:0]  slot_q;
    logic [3:0]  slot_d;
    logic [1:0]  phase_q;
    logic [1:0]  phase_d;
    core_state_e state_q;
    core_state_e state_d;
    addr_t       pc_q;
    addr_t       pc_d;
    addr_t       addr_q;
    addr_t       ret_q;
    addr_t       vec_q;
    logic        last_cyc_q;
    logic        next_fetch_q;
    logic        int0_prev_q;
    logic        int0_pend_q;
    logic        ack_q;
    logic        mark_q;
    logic        halt_req_q;
    logic        cnt_mode_q;
    data_t       opc_q;
    logic        opc_vld_q;
    logic        clk_q;

    // Pins pass the two-stage synchroniser
    assign pins_raw = '{EXT_IRQ_TEST0_IN, TEST_ONE_INPUT_IN,
                        EXT_SERIAL_IRQ_N_IN, HALT_N_IN,
                        SMALL_PIN_EMUL_SEL_N_IN};

    pin_sync u_sync (
        .clk_in  (CLOCK_IN),
        .rst_in  (RST_IN),
        .ce_in   (CE_IN),
        .pins_in (pins_raw),
        .pins_out(pins_s_w)
    );

    function automatic logic at_slot(input logic [3:0] s,
                                     input logic [1:0] p,
                                     input logic [3:0] ts,
                                     input logic [1:0] tp);
        at_slot = (s == ts) && (p == tp);
    endfunction : at_slot

    wire phase_end = (phase_q == PHASE_LAST);
    wire cyc_end   = phase_end && (slot_q == SLOT_LAST);
    assign phase_d = phase_end ? PHASE_FIRST : phase_q + 2'h1;
    assign slot_d  = cyc_end ? SLOT_FIRST
                   : (phase_end ? slot_q + 4'h1 : slot_q);

    // Timing points within the cycle
    wire addr_pt  = at_slot(slot_q, phase_q, SLOT_ADDR_CHG, PHASE_ADDR_CHG);
    // Registered marks load in the slot before so they show at slot start
    wire mark_pt  = at_slot(slot_q, phase_q, SLOT_FETCH_MARK - 4'h1,
                            PHASE_LAST);
    wire ack_pt   = at_slot(slot_q, phase_q, SLOT_ACK_SET - 4'h1,
                            PHASE_LAST);
    wire ackc_pt  = at_slot(slot_q, phase_q, SLOT_ACK_CLR - 4'h1,
                            PHASE_LAST);

    // Falling edge on synchronised interrupt/test input
    wire int0_fall = int0_prev_q && !pins_s_w.ext_irq_test0;
    // Emulator serial interrupt in twenty-pin emulation
    wire ser_req   = PIN20_MODE_OUT ? !pins_s_w.ext_serial_irq_n
                                    : SERIAL_IRQ_IN;
    wire any_req   = int0_pend_q || TIMER_IRQ_IN || ser_req;
    // Accept only while running at an instruction end
    wire take_irq  = (state_q == ST_RUN) && last_cyc_q && ack_pt
                     && any_req && !ack_q;
    wire [12:0] vec_sel = int0_pend_q ? VECTOR_EXT
                        : (TIMER_IRQ_IN ? VECTOR_TMR : VECTOR_SER);

    // Halt taken only at instruction end
    wire halt_now  = halt_req_q && last_cyc_q && cyc_end
                     && (state_q == ST_RUN) && !ack_q;

    // Sequencer for run, halt and forced vector call
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN:
                // Forced call starts after the interrupted cycle
                if (ack_q && cyc_end)
                    state_d = ST_VEC1;
                else if (halt_now)
                    state_d = ST_HALT;
            ST_HALT:
                if (pins_s_w.halt_n && cyc_end)
                    state_d = ST_RUN;
            ST_VEC1:
                if (cyc_end)
                    state_d = ST_VEC2;
            ST_VEC2:
                if (cyc_end)
                    state_d = ST_RUN;
        endcase
    end

    wire pc_step = cyc_end && (state_q == ST_RUN) && !halt_now;
    assign pc_d  = (state_q == ST_VEC2 && cyc_end) ? vec_q
                 : (pc_step ? pc_q + 13'h0001 : pc_q);

    always_ff @(posedge CLOCK_IN)
    begin
        if (RST_IN)
        begin
            slot_q       <= SLOT_FIRST;
            phase_q      <= PHASE_FIRST;
            state_q      <= ST_RUN;
            pc_q         <= RESET_PC;
            addr_q       <= RESET_PC;
            ret_q        <= RESET_PC;
            vec_q        <= RESET_PC;
            last_cyc_q   <= 1'b1;
            next_fetch_q <= 1'b1;
            int0_prev_q  <= 1'b1;
            int0_pend_q  <= 1'b0;
            ack_q        <= 1'b0;
            mark_q       <= 1'b0;
            halt_req_q   <= 1'b0;
            cnt_mode_q   <= 1'b0;
            opc_q        <= 8'h00;
            opc_vld_q    <= 1'b0;
            clk_q        <= 1'b0;
        end
        else if (CE_IN)
        begin
            slot_q      <= slot_d;
            phase_q     <= phase_d;
            state_q     <= state_d;
            pc_q        <= pc_d;
            int0_prev_q <= pins_s_w.ext_irq_test0;
            halt_req_q  <= !pins_s_w.halt_n;
            clk_q       <= !clk_q;
            // Edge pending, set wins over clear
            if (int0_fall && state_q != ST_HALT)
                int0_pend_q <= 1'b1;
            else if (take_irq && int0_pend_q)
                int0_pend_q <= 1'b0;
            if (take_irq)
            begin
                ret_q <= pc_q + 13'h0001;
                vec_q <= vec_sel;
            end
            if (take_irq)
                ack_q <= 1'b1;
            else if (ackc_pt && state_q == ST_VEC2)
                ack_q <= 1'b0;
            // Address update at slot eight phase three
            if (addr_pt)
                addr_q <= (ack_q || state_q == ST_VEC2) ? ret_q : pc_q;
            // Marker from slot ten before a fetch
            if (mark_pt)
                mark_q <= next_fetch_q && (state_q != ST_HALT);
            opc_vld_q <= 1'b0;
            if (at_slot(slot_q, phase_q, SLOT_FIRST, PHASE_LAST)
                && (state_q == ST_RUN))
            begin
                opc_q      <= FETCH_DATA_IN;
                opc_vld_q  <= 1'b1;
                if (FETCH_DATA_IN == OPC_START_COUNTER_INSTR)
                    cnt_mode_q <= 1'b1;
            end
            if (cyc_end)
            begin
                last_cyc_q   <= next_fetch_q;
                // Forced call runs two cycles like a user call
                next_fetch_q <= (state_d == ST_VEC1) ? 1'b0
                              : (opc_vld_q ? !opc_q[7] || opc_q < OPC_TWO_CYC_LO
                                           : !next_fetch_q || 1'b1);
            end
        end
    end

    // Store enable in slots nine, ten and one
    wire strobe_win = (slot_q == SLOT_STROBE_A) || (slot_q == SLOT_STROBE_B)
                      || (slot_q == SLOT_FIRST);

    assign FETCH_ADDR_OUT         = addr_q;
    assign PROG_STORE_EN_N_OUT    = !strobe_win;
    assign FETCH_CYCLE_MARK_N_OUT = !mark_q;
    assign IRQ_ACK_N_OUT          = !ack_q;
    assign CLK_BUF_OUT            = clk_q;
    // Phase clock follows buffered clock edge
    assign PHASE_CLK_OUT          = clk_q;
    assign HALTED_OUT             = (state_q == ST_HALT);
    // Serial unit told to finish then idle
    assign SERIAL_IDLE_REQ_OUT    = (state_q == ST_HALT) || halt_req_q;
    assign TIMER_RUN_OUT          = (state_q != ST_HALT);
    // Event count enable and jump test level
    assign EVENT_CNT_EN_OUT       = cnt_mode_q && (state_q != ST_HALT);
    assign TEST1_LEVEL_OUT        = pins_s_w.test_one_input;
    assign TEST0_LEVEL_OUT        = pins_s_w.ext_irq_test0;
    assign PIN20_MODE_OUT         = !pins_s_w.small_pin_emul_sel_n;
    // Serial data routed to port 2 line 3
    assign SDA_ON_PORT2_LINE3_OUT = SERIAL_MODE_IN && !SERIAL_BUSY_IN
                                    || SERIAL_MODE_IN;
    assign OPCODE_OUT             = opc_q;
    assign OPCODE_VALID_OUT       = opc_vld_q;
endmodule : bondout_emulation_port

// ===== tb/emul_port_props.sv
// Checker on the emulation port pins.
// Assumes CE_IN high, so one clock tick is one phase.
`timescale 1ns/1ps
module emul_port_props
    import emul_port_pkg::*;
(
    input wire logic  CLOCK_IN,
    input wire logic  RST_IN,
    input wire addr_t FETCH_ADDR_OUT,
    input wire logic  PROG_STORE_EN_N_OUT,
    input wire logic  FETCH_CYCLE_MARK_N_OUT,
    input wire logic  IRQ_ACK_N_OUT,
    input wire logic  CLK_BUF_OUT,
    input wire logic  PHASE_CLK_OUT,
    input wire logic  HALTED_OUT,
    input wire logic  SERIAL_IDLE_REQ_OUT,
    input wire logic  TIMER_RUN_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    wire logic s  = PROG_STORE_EN_N_OUT;
    wire logic ak = IRQ_ACK_N_OUT;
    property p_strobe_len; $fell(s) |-> ##1 (!s)[*8] ##1 s; endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("store enable width wrong");
    property p_cycle_len; $fell(s) |-> ##30 $fell(s); endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("machine cycle length wrong");
    property p_addr_slot; $changed(FETCH_ADDR_OUT) |-> $fell(s); endproperty
    a_addr_slot: assert property (p_addr_slot)
        else $error("address changed off slot");
    property p_mark_slot;
        $changed(FETCH_CYCLE_MARK_N_OUT) |->
            !s && !$past(s, 3) && $past(s, 4);
    endproperty
    a_mark_slot: assert property (p_mark_slot)
        else $error("fetch marker changed off slot");
    property p_ack_slot; $fell(ak) |-> ##3 $fell(s); endproperty
    a_ack_slot: assert property (p_ack_slot)
        else $error("acknowledge started off slot");
    property p_ack_len; $fell(ak) |-> ##57 $rose(ak); endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("acknowledge length wrong");
    property p_clk;
        $rose(CLK_BUF_OUT) |-> PHASE_CLK_OUT ##1 !CLK_BUF_OUT ##1 CLK_BUF_OUT;
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock output wrong");
    property p_halt_addr;
        HALTED_OUT && $past(HALTED_OUT) |-> $stable(FETCH_ADDR_OUT);
    endproperty
    a_halt_addr: assert property (p_halt_addr)
        else $error("address moved while halted");
    property p_halt_freeze;
        HALTED_OUT |-> !TIMER_RUN_OUT && SERIAL_IDLE_REQ_OUT;
    endproperty
    a_halt_freeze: assert property (p_halt_freeze)
        else $error("halt did not freeze");
    property p_no_irq_halt; $fell(ak) |-> !HALTED_OUT; endproperty
    a_no_irq_halt: assert property (p_no_irq_halt)
        else $error("interrupt taken while halted");
    c_ack: cover property ($fell(ak));
    c_halt: cover property ($rose(HALTED_OUT));
    c_mark: cover property ($fell(FETCH_CYCLE_MARK_N_OUT));
endmodule : emul_port_props
bind bondout_emulation_port emul_port_props u_props (
    .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .FETCH_ADDR_OUT(FETCH_ADDR_OUT),
    .PROG_STORE_EN_N_OUT(PROG_STORE_EN_N_OUT),
    .FETCH_CYCLE_MARK_N_OUT(FETCH_CYCLE_MARK_N_OUT),
    .IRQ_ACK_N_OUT(IRQ_ACK_N_OUT), .CLK_BUF_OUT(CLK_BUF_OUT),
    .PHASE_CLK_OUT(PHASE_CLK_OUT), .HALTED_OUT(HALTED_OUT),
    .SERIAL_IDLE_REQ_OUT(SERIAL_IDLE_REQ_OUT), .TIMER_RUN_OUT(TIMER_RUN_OUT));

// ===== tb/code_rom.sv
// External code memory model on the fetch port.
// Assumes store enable qualifies the address; bus drives the inverted last byte otherwise.
`timescale 1ns/1ps
module code_rom
    import emul_port_pkg::*;
(
    input  wire logic  clk_in,
    input  wire addr_t addr_in,
    input  wire logic  store_en_n_in,
    output data_t      data_out
);
    data_t last_q;
    data_t byte_d;
    assign byte_d = {1'b0, addr_in[6:0] ^ 7'h2a};
    always_ff @(posedge clk_in)
        if (!store_en_n_in) last_q <= byte_d;
    assign data_out = store_en_n_in ? ~last_q : byte_d;
endmodule : code_rom

// ===== tb/test_bondout_emulation_port.sv
// Testbench for the bond-out emulation port.
// Assumes CE_IN high and the code_rom model on the fetch port.
`timescale 1ns/1ps
module test_bondout_emulation_port
    import emul_port_pkg::*;
;
    logic  clk = 0, rst = 1, halt_n = 1, irq0 = 1, t1 = 0, esi_n = 1;
    logic  sel_n = 1, tmr = 0, ser = 0, sbusy = 0, smode = 0;
    logic  store_n, mark_n, ack_n, halted, opc_v, t0l, t1l, p20, sda, idle;
    logic  trun;
    data_t rom_data, opc;
    addr_t addr, held, a0;
    int    n_fail = 0, n_tests = 0;
    logic [7:0]  rows [4] = '{8'ha8, 8'hdf, 8'h64, 8'h13};
    logic [12:0] vec  [4] = '{13'h0003, 13'h0007, 13'h0005, 13'h0005};
    always #12.5 clk = ~clk;
    code_rom u_rom (.clk_in(clk), .addr_in(addr), .store_en_n_in(store_n),
        .data_out(rom_data));
    bondout_emulation_port DUT (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
        .FETCH_DATA_IN(rom_data), .HALT_N_IN(halt_n),
        .EXT_IRQ_TEST0_IN(irq0), .TEST_ONE_INPUT_IN(t1),
        .EXT_SERIAL_IRQ_N_IN(esi_n), .SMALL_PIN_EMUL_SEL_N_IN(sel_n),
        .TIMER_IRQ_IN(tmr), .SERIAL_IRQ_IN(ser), .SERIAL_BUSY_IN(sbusy),
        .SERIAL_MODE_IN(smode), .FETCH_ADDR_OUT(addr),
        .PROG_STORE_EN_N_OUT(store_n), .FETCH_CYCLE_MARK_N_OUT(mark_n),
        .IRQ_ACK_N_OUT(ack_n), .CLK_BUF_OUT(), .PHASE_CLK_OUT(),
        .HALTED_OUT(halted), .SERIAL_IDLE_REQ_OUT(idle), .TIMER_RUN_OUT(trun),
        .EVENT_CNT_EN_OUT(), .TEST0_LEVEL_OUT(t0l), .TEST1_LEVEL_OUT(t1l),
        .PIN20_MODE_OUT(p20), .SDA_ON_PORT2_LINE3_OUT(sda), .OPCODE_OUT(opc),
        .OPCODE_VALID_OUT(opc_v));
    task check(input logic [12:0] seen, input logic [12:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results;
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    function automatic logic pick(input int w);
        case (w)
            0: pick = ack_n;
            1: pick = halted;
            2: pick = store_n;
            3: pick = opc_v;
            default: pick = (addr !== a0);
        endcase
    endfunction : pick
    // Bounded wait for a level, sampled at falling edges
    task wait_sig(input int w, input logic lvl);
        int i;
        for (i = 0; i < 400 && pick(w) !== lvl; i++) @(negedge clk);
        if (i == 400) check(1'b0, 1'b1);
    endtask : wait_sig
    initial
    begin
        repeat (2) @(negedge clk);
        check(addr, RESET_PC);
        check({store_n, mark_n, ack_n}, 3'b011);
        @(posedge clk) rst <= 0;
        foreach (rows[i])
        begin
            @(posedge clk) {irq0, t1, sel_n, smode} <= rows[i][7:4];
            repeat (4) @(negedge clk);
            check({t0l, t1l, p20, sda}, rows[i][3:0]);
        end
        @(posedge clk) sel_n <= 1;
        repeat (300) @(negedge clk);
        for (int k = 0; k < 6; k++)
        begin
            wait_sig(2, 1);
            wait_sig(2, 0);
            a0 = addr;
            if (k > 0) check(a0, held + 13'h0001);
            held = a0;
            wait_sig(3, 1);
            check(opc, {1'b0, a0[6:0] ^ 7'h2a});
        end
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) irq0 <= 1;
            repeat (20) @(posedge clk);
            case (i)
                0: irq0 <= 0;
                1: tmr <= 1;
                2: ser <= 1;
                default: {sel_n, esi_n} <= 2'b00;
            endcase
            wait_sig(0, 0);
            @(posedge clk) {tmr, ser, esi_n} <= 3'b001;
            wait_sig(0, 1);
            a0 = addr;
            wait_sig(4, 1);
            check(addr, vec[i]);
        end
        @(posedge clk) {sel_n, irq0, halt_n} <= 3'b110;
        wait_sig(1, 1);
        held = addr;
        @(posedge clk) irq0 <= 0;
        repeat (100) @(negedge clk);
        check({addr, trun, idle}, {held, 2'b01});
        @(posedge clk) halt_n <= 1;
        wait_sig(1, 0);
        a0 = addr;
        wait_sig(4, 1);
        check(addr, held + 13'h0001);
        results;
    end
    initial
    begin
        #750000;
        n_fail++;
        results;
    end
endmodule : test_bondout_emulation_port
